// ### design/sfl_pkg.sv
// Shared constants and frame layout for the serial frame and load control block
package sfl_pkg;

    // Frame lengths in serial clock falling edges
    localparam int unsigned FRAME_BITS     = 24;
    localparam int unsigned CRC_FRAME_BITS = 32;
    localparam int unsigned CNT_W          = 6;
    localparam int unsigned CRC_W          = 8;
    localparam logic [7:0]  CRC_POLY       = 8'h07;
    localparam logic [7:0]  CRC_INIT       = 8'h00;

    // Channel and data sizes
    localparam int unsigned CHANNELS       = 4;
    localparam int unsigned CHAN_W         = 2;
    localparam int unsigned DATA_W         = 16;
    localparam logic [15:0] DATA_RESET     = 16'h0000;

    // Pin synchroniser depth and pin slot order
    localparam int unsigned SYNC_STAGES    = 3;
    localparam int unsigned PIN_COUNT      = 6;
    localparam int unsigned PIN_SCLK       = 0;
    localparam int unsigned PIN_FRAME_N    = 1;
    localparam int unsigned PIN_DATA_IN    = 2;
    localparam int unsigned PIN_LOAD_N     = 3;
    localparam int unsigned PIN_ADDR0      = 4;
    localparam int unsigned PIN_ADDR1      = 5;
    // Reset levels match the idle pins so no false edge follows reset
    localparam logic [5:0]  PIN_RESET      = 6'h0B;

    // Interface rate limit against the sampling clock
    localparam int unsigned SCLK_MAX_KHZ   = 30000;
    localparam int unsigned CORE_CLK_KHZ   = 20000;
    localparam int unsigned CORE_PERIOD_NS = 50;
    localparam int unsigned MIN_SCLK_HALF_CYC = SYNC_STAGES - 1;

    // 24-bit frame body, MSB first on the wire
    typedef struct packed {
        logic                 rd;
        logic [1:0]           board_addr;
        logic [CHAN_W-1:0]    chan;
        logic [2:0]           rsvd;
        logic [DATA_W-1:0]    data;
    } sfl_frame_t;

    // Filtered view of the pins
    typedef struct packed {
        logic       board_addr_bit1;
        logic       board_addr_bit0;
        logic       output_load_n;
        logic       serial_data_in;
        logic       frame_n;
        logic       sclk;
    } sfl_pins_t;

endpackage : sfl_pkg

// ### design/sfl_serial_frame_load.sv
// Serial input port with frame decode, read-back and deferred output load
// Notes on behaviour
// (R1) With frame sync low, each serial clock falling edge shifts one input bit into the shift register.
// (R2) The host keeps each input bit stable around the falling edge that samples it.
// (R3) The serial clock stays within the interface rate limit; the port needs each clock level held for at least MIN_SCLK_HALF_CYC core clock cycles.
// (R4) After a read request, the next frame shifts the selected channel word out, one bit per clock.
// (R5) With the load input low at frame close, the addressed channel output is written at once.
// (R6) With the load input high, only the input register is written and waits for a load falling edge.
// (R7) One load falling edge moves every pending input register to its output together.
// (R8) The load input is always driven to a defined level, never left floating.
// (R9) The two board address pins must match the frame address for the frame to be accepted.
// (R10) Boards should avoid strapping both address pins low when error checking is in use.
// (R11) The host raises frame sync after the last falling edge of a 24 or 32 bit frame.
// (R12) While clear is active, no channel output register is written.
// (R13) With frame sync high, serial clock edges are ignored and the shift register holds.
// (R14) A frame is acted on only when it holds exactly the expected bit count at close.
module sfl_serial_frame_load #(
    parameter int unsigned CHANNELS = sfl_pkg::CHANNELS,
    parameter int unsigned DATA_W   = sfl_pkg::DATA_W
) (
    input  wire logic                           core_clk_i,
    input  wire logic                           nrst_i,
    input  wire logic                           sclk_i,
    input  wire logic                           frame_n_i,
    input  wire logic                           serial_data_in_i,
    input  wire logic                           output_load_n_i,
    input  wire logic                           board_addr_bit0_i,
    input  wire logic                           board_addr_bit1_i,
    input  wire logic                           packet_error_check_i,
    input  wire logic                           clear_i,
    output logic                                serial_data_out_o,
    output logic [CHANNELS-1:0][DATA_W-1:0]     dac_out_o,
    output logic [CHANNELS-1:0]                 pending_o,
    output logic                                frame_accept_o,
    output logic                                crc_error_o
);

    typedef enum logic [1:0] {
        SFL_IDLE  = 2'b00,
        SFL_SHIFT = 2'b01,
        SFL_CLOSE = 2'b10
    } sfl_state_t;

    localparam int unsigned SH_W = sfl_pkg::CRC_FRAME_BITS;
    localparam int unsigned FW   = sfl_pkg::FRAME_BITS;

    // CRC-8 over the 24-bit frame body, MSB first
    function automatic logic [7:0] sfl_crc8(input logic [FW-1:0] body);
        logic [7:0] crc;
        crc = sfl_pkg::CRC_INIT;
        for (int i = FW - 1; i >= 0; i--) begin
            if (crc[7] ^ body[i]) begin
                crc = {crc[6:0], 1'b0} ^ sfl_pkg::CRC_POLY;
            end else begin
                crc = {crc[6:0], 1'b0};
            end
        end
        return crc;
    endfunction : sfl_crc8

    // Three-stage synchronisers, second and third must agree
    logic [sfl_pkg::PIN_COUNT-1:0]  pin_raw;
    logic [sfl_pkg::PIN_COUNT-1:0]  sync1_reg;
    logic [sfl_pkg::PIN_COUNT-1:0]  sync2_reg;
    logic [sfl_pkg::PIN_COUNT-1:0]  sync3_reg;
    sfl_pkg::sfl_pins_t             pin_reg;
    sfl_pkg::sfl_pins_t             pin_prev_reg;

    assign pin_raw = {board_addr_bit1_i, board_addr_bit0_i, output_load_n_i,
                      serial_data_in_i, frame_n_i, sclk_i};

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_reg <= sfl_pkg::PIN_RESET;
            sync2_reg <= sfl_pkg::PIN_RESET;
            sync3_reg <= sfl_pkg::PIN_RESET;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    generate
        for (genvar p = 0; p < sfl_pkg::PIN_COUNT; p++) begin : g_filter
            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pin_reg[p] <= sfl_pkg::PIN_RESET[p];
                end else if (sync2_reg[p] == sync3_reg[p]) begin
                    pin_reg[p] <= sync3_reg[p];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_prev_reg <= sfl_pkg::PIN_RESET;
        end else begin
            pin_prev_reg <= pin_reg;
        end
    end

    logic sclk_fall;
    logic sclk_rise;
    logic frame_start;
    logic frame_end;
    logic load_fall;

    assign sclk_fall   = pin_prev_reg.sclk && !pin_reg.sclk;  // (R3)
    assign sclk_rise   = !pin_prev_reg.sclk && pin_reg.sclk;
    assign frame_start = pin_prev_reg.frame_n && !pin_reg.frame_n;
    assign frame_end   = !pin_prev_reg.frame_n && pin_reg.frame_n;
    assign load_fall   = pin_prev_reg.output_load_n && !pin_reg.output_load_n;

    // Frame capture
    sfl_state_t                 state_reg;
    logic [SH_W-1:0]            shift_reg;
    logic [sfl_pkg::CNT_W-1:0]  count_reg;
    logic                       crc_mode_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= SFL_IDLE;
        end else begin
            case (state_reg)
                SFL_IDLE:  if (frame_start) state_reg <= SFL_SHIFT;
                SFL_SHIFT: if (frame_end) state_reg <= SFL_CLOSE;
                SFL_CLOSE: state_reg <= SFL_IDLE;
                default:   state_reg <= SFL_IDLE;
            endcase
        end
    end

    // Error checking mode is latched per frame so a mid-frame change cannot split it
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            crc_mode_reg <= 1'b0;
        end else if (frame_start) begin
            crc_mode_reg <= packet_error_check_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_reg <= '0;
            count_reg <= '0;
        end else if (frame_start) begin
            count_reg <= '0;
        end else if (state_reg == SFL_SHIFT && !pin_reg.frame_n && sclk_fall) begin  // (R1) (R13)
            shift_reg <= {shift_reg[SH_W-2:0], pin_reg.serial_data_in};  // (R1)
            if (count_reg != '1) begin
                count_reg <= count_reg + sfl_pkg::CNT_W'(1);
            end
        end
    end

    // Frame decode at close
    sfl_pkg::sfl_frame_t    frame_body;
    logic [7:0]             frame_crc;
    logic                   len_ok;
    logic                   crc_ok;
    logic                   addr_ok;
    logic                   take;

    always_comb begin
        if (crc_mode_reg) begin
            frame_body = shift_reg[SH_W-1:sfl_pkg::CRC_W];
            frame_crc  = shift_reg[sfl_pkg::CRC_W-1:0];
            len_ok     = (count_reg == sfl_pkg::CNT_W'(sfl_pkg::CRC_FRAME_BITS));  // (R14)
            crc_ok     = (sfl_crc8(frame_body) == frame_crc);
        end else begin
            frame_body = shift_reg[FW-1:0];
            frame_crc  = '0;
            len_ok     = (count_reg == sfl_pkg::CNT_W'(FW));  // (R14)
            crc_ok     = 1'b1;
        end
        addr_ok = (frame_body.board_addr ==
                   {pin_reg.board_addr_bit1, pin_reg.board_addr_bit0});  // (R9)
        take    = (state_reg == SFL_CLOSE) && len_ok && crc_ok && addr_ok;  // (R14)
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_accept_o <= 1'b0;
            crc_error_o    <= 1'b0;
        end else begin
            frame_accept_o <= take;
            crc_error_o    <= (state_reg == SFL_CLOSE) && len_ok && !crc_ok;
        end
    end

    // Channel input and output registers
    logic [CHANNELS-1:0][DATA_W-1:0] input_reg;

    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
            logic hit;
            assign hit = take && !frame_body.rd &&
                         (frame_body.chan == sfl_pkg::CHAN_W'(c));

            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    input_reg[c] <= sfl_pkg::DATA_RESET;
                end else if (hit) begin
                    input_reg[c] <= frame_body.data;
                end
            end

            // Clear blocks output writes; a blocked word stays pending for the next load edge
            always_ff @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    dac_out_o[c] <= sfl_pkg::DATA_RESET;
                    pending_o[c] <= 1'b0;
                end else if (hit && !pin_reg.output_load_n) begin
                    if (!clear_i) begin  // (R12)
                        dac_out_o[c] <= frame_body.data;  // (R5)
                        pending_o[c] <= 1'b0;
                    end else begin
                        pending_o[c] <= 1'b1;
                    end
                end else if (hit) begin
                    pending_o[c] <= 1'b1;  // (R6)
                end else if (load_fall && pending_o[c] && !clear_i) begin  // (R7) (R12)
                    dac_out_o[c] <= input_reg[c];  // (R6) (R7)
                    pending_o[c] <= 1'b0;
                end
            end
        end
    endgenerate

    // Read-back: request in one frame, word shifted out in the next
    sfl_pkg::sfl_frame_t    rb_word;
    logic [FW-1:0]          rb_shift_reg;

    always_comb begin
        rb_word            = '0;
        rb_word.board_addr = frame_body.board_addr;
        rb_word.chan       = frame_body.chan;
        rb_word.data       = dac_out_o[frame_body.chan];
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rb_shift_reg      <= '0;
            serial_data_out_o <= 1'b0;
        end else if (take && frame_body.rd) begin
            rb_shift_reg <= rb_word;
        end else if (frame_start) begin
            serial_data_out_o <= rb_shift_reg[FW-1];  // (R4)
            rb_shift_reg      <= {rb_shift_reg[FW-2:0], 1'b0};
        end else if (state_reg == SFL_SHIFT && !pin_reg.frame_n && sclk_rise &&
                     count_reg != '0) begin
            serial_data_out_o <= rb_shift_reg[FW-1];  // (R4)
            rb_shift_reg      <= {rb_shift_reg[FW-2:0], 1'b0};
        end
    end

endmodule : sfl_serial_frame_load

// ### tb/sfl_serial_frame_load_asserts.sv
// Concurrent checks on the serial frame and load control ports
module sfl_serial_frame_load_asserts #(
    parameter int unsigned CHANNELS = 4,
    parameter int unsigned DATA_W   = 16
) (
    input wire logic                             core_clk_i,
    input wire logic                             nrst_i,
    input wire logic                             sclk_i,
    input wire logic                             frame_n_i,
    input wire logic                             serial_data_in_i,
    input wire logic                             output_load_n_i,
    input wire logic                             board_addr_bit0_i,
    input wire logic                             board_addr_bit1_i,
    input wire logic                             packet_error_check_i,
    input wire logic                             clear_i,
    input wire logic                             serial_data_out_o,
    input wire logic [CHANNELS-1:0][DATA_W-1:0]  dac_out_o,
    input wire logic [CHANNELS-1:0]              pending_o,
    input wire logic                             frame_accept_o,
    input wire logic                             crc_error_o
);
    // Cycles since the load pin fell, saturating so stale falls never qualify
    logic [3:0] ld_cnt_reg;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ld_cnt_reg <= 4'hF;
        end else if ($fell(output_load_n_i)) begin
            ld_cnt_reg <= 4'h0;
        end else if (ld_cnt_reg != 4'hF) begin
            ld_cnt_reg <= ld_cnt_reg + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    chk_accept_pulse: assert property (frame_accept_o |=> !frame_accept_o)
        else $error("accept pulse longer than one cycle");
    chk_crc_pulse: assert property (crc_error_o |=> !crc_error_o)
        else $error("check error pulse longer than one cycle");
    chk_crc_mode: assert property (crc_error_o |-> packet_error_check_i && !frame_accept_o)
        else $error("check error outside checked mode or with accept");
    chk_dac_cause: assert property ($changed(dac_out_o) |-> frame_accept_o || ld_cnt_reg <= 4'hA)
        else $error("output changed without write or load");
    chk_clear_block: assert property ($changed(dac_out_o) |-> !$past(clear_i))
        else $error("output written while clear active");
    chk_pend_cause: assert property (|(pending_o & ~$past(pending_o)) |-> frame_accept_o)
        else $error("pending set without accepted frame");
    chk_load_all: assert property (($fell(output_load_n_i) && |pending_o && !clear_i)
        |-> ##[2:9] (pending_o == '0)) else $error("load edge left channels pending");
    chk_accept_close: assert property (frame_accept_o |-> $past(frame_n_i, 3)
        && !$past(frame_n_i, 14)) else $error("accept not tied to frame close");
endmodule : sfl_serial_frame_load_asserts

bind sfl_serial_frame_load sfl_serial_frame_load_asserts #(.CHANNELS(CHANNELS), .DATA_W(DATA_W))
    u_chk (.core_clk_i, .nrst_i, .sclk_i, .frame_n_i, .serial_data_in_i, .output_load_n_i,
    .board_addr_bit0_i, .board_addr_bit1_i, .packet_error_check_i, .clear_i,
    .serial_data_out_o, .dac_out_o, .pending_o, .frame_accept_o, .crc_error_o);

// ### tb/sfl_host_model.sv
// Host side of the serial link: frames words out and collects read-back bits
module sfl_host_model (
    output logic      sclk_o,
    output logic      frame_n_o,
    output logic      data_o,
    input  wire logic data_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] rx;
    initial begin
        sclk_o = 1'b1;
        frame_n_o = 1'b1;
        data_o = 1'b0;
        rx = '0;
    end
    // Clock stands high between frames; read-back sampled late in low phase
    task automatic send(input logic [31:0] word, input int n);
        frame_n_o = 1'b0;
        #400;
        for (int i = n - 1; i >= 0; i--) begin
            data_o = word[i];
            #200 sclk_o = 1'b0;
            #199 rx = {rx[30:0], data_i};
            #1 sclk_o = 1'b1;
        end
        #200 frame_n_o = 1'b1;
        data_o = ~data_o;
    endtask : send
endmodule : sfl_host_model

// ### tb/serial_frame_and_load_control_test.sv
// Self-checking bench for the serial frame and load control block
module serial_frame_and_load_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic             core_clk, rst_n, load_n, addr0, addr1, crc_mode, clear;
    logic             sclk, frame_n, din, dout, accept, crc_err;
    logic [3:0][15:0] dac;
    logic [3:0]       pend;
    int               num_errors = 0, tests_run = 0, acc_cnt = 0, crc_cnt = 0;

    sfl_host_model host (.sclk_o(sclk), .frame_n_o(frame_n), .data_o(din), .data_i(dout));
    sfl_serial_frame_load dut (.core_clk_i(core_clk), .nrst_i(rst_n), .sclk_i(sclk),
        .frame_n_i(frame_n), .serial_data_in_i(din), .output_load_n_i(load_n),
        .board_addr_bit0_i(addr0), .board_addr_bit1_i(addr1), .packet_error_check_i(crc_mode),
        .clear_i(clear), .serial_data_out_o(dout), .dac_out_o(dac), .pending_o(pend),
        .frame_accept_o(accept), .crc_error_o(crc_err));

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        acc_cnt += int'(accept === 1'b1);
        crc_cnt += int'(crc_err === 1'b1);
    end

    function automatic logic [23:0] body(logic rd, logic [1:0] ch, logic [15:0] d);
        return {rd, 2'b10, ch, 3'b000, d};
    endfunction : body
    function automatic logic [7:0] crc8(logic [23:0] b);
        logic [7:0] c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8

    task automatic chk_vec(string what, logic [23:0] exp, logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_vec
    task automatic drive(logic ld, logic clr, logic pm);
        @(posedge core_clk);
        #1 {load_n, clear, crc_mode} = {ld, clr, pm};
    endtask : drive
    // One frame, then a settle window long enough for the pulse and the gap
    task automatic xfer(logic [31:0] w, int n, int ea, int ep);
        int a0 = acc_cnt;
        int p0 = crc_cnt;
        host.send(w, n);
        repeat (20) @(posedge core_clk);
        #1 chk_vec("accepts", 24'(ea), 24'(acc_cnt - a0));
        chk_vec("crc errors", 24'(ep), 24'(crc_cnt - p0));
    endtask : xfer

    task automatic t_immediate;
        for (int c = 0; c < 4; c++) begin
            xfer({8'h00, body(1'b0, 2'(c), 16'h1111 * 16'(c + 1))}, 24, 1, 0);
            chk_vec("dac now", 24'(16'h1111 * 16'(c + 1)), 24'(dac[c]));
        end
    endtask : t_immediate
    task automatic t_deferred;
        drive(1'b1, 1'b0, 1'b0);
        xfer({8'h00, body(1'b0, 2'h0, 16'hA5A5)}, 24, 1, 0);
        xfer({8'h00, body(1'b0, 2'h2, 16'h5A5A)}, 24, 1, 0);
        chk_vec("held", 24'h111333, {dac[0][11:0], dac[2][11:0]});
        chk_vec("pending", 24'h000005, 24'(pend));
        drive(1'b0, 1'b0, 1'b0);
        repeat (12) @(posedge core_clk);
        #1 chk_vec("loaded", 24'h5A5A5A, {dac[0][11:0], dac[2][11:0]});
        chk_vec("pending", 24'h000000, 24'(pend));
    endtask : t_deferred
    task automatic t_refuse;
        xfer({8'h00, body(1'b0, 2'h1, 16'hDEAD)}, 23, 0, 0);
        xfer({8'h00, body(1'b0, 2'h1, 16'hDEAD)}, 25, 0, 0);
        xfer({8'h00, 1'b0, 2'b01, 2'h1, 3'b000, 16'hDEAD}, 24, 0, 0);
        chk_vec("refused", 24'h002222, 24'(dac[1]));
    endtask : t_refuse
    task automatic t_clear;
        drive(1'b0, 1'b1, 1'b0);
        xfer({8'h00, body(1'b0, 2'h3, 16'hBEEF)}, 24, 1, 0);
        chk_vec("blocked", 24'h004444, 24'(dac[3]));
        drive(1'b1, 1'b0, 1'b0);
        repeat (6) @(posedge core_clk);
        drive(1'b0, 1'b0, 1'b0);
        repeat (12) @(posedge core_clk);
        #1 chk_vec("released", 24'h00BEEF, 24'(dac[3]));
    endtask : t_clear
    task automatic t_readback;
        xfer({8'h00, body(1'b1, 2'h1, 16'h0000)}, 24, 1, 0);
        xfer({8'h00, 1'b0, 2'b01, 2'h1, 3'b000, 16'h0000}, 24, 0, 0);
        chk_vec("readback", body(1'b0, 2'h1, 16'h2222), host.rx[23:0]);
    endtask : t_readback
    // Mid-run reset: outputs clear, and the port works again after the settle time
    task automatic t_reset;
        drive(1'b0, 1'b0, 1'b0);
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk_vec("reset dac", 24'h000000, 24'(dac[0] | dac[1] | dac[2] | dac[3]));
        chk_vec("reset flags", 24'h000000, {17'h00000, pend, dout, accept, crc_err});
        rst_n = 1'b1;
        repeat (10) @(posedge core_clk);
        #1 xfer({8'h00, body(1'b0, 2'h2, 16'h7E7E)}, 24, 1, 0);
        chk_vec("after reset", 24'h007E7E, 24'(dac[2]));
    endtask : t_reset
    task automatic t_crc;
        logic [23:0] w = body(1'b0, 2'h0, 16'h0F0F);
        drive(1'b0, 1'b0, 1'b1);
        xfer({w, crc8(w)}, 32, 1, 0);
        xfer({w ^ 24'h0000FF, crc8(w)}, 32, 0, 1);
        chk_vec("crc dac", 24'h000F0F, 24'(dac[0]));
        xfer({8'h00, w}, 24, 0, 0);
        drive(1'b0, 1'b0, 1'b0);
    endtask : t_crc

    task automatic close_out;
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    initial begin
        {core_clk, rst_n, load_n, clear, crc_mode} = 5'h00;
        {addr1, addr0} = 2'b10;
        repeat (5) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (10) @(posedge core_clk);
        #1 t_immediate();
        t_deferred();
        t_refuse();
        t_clear();
        t_readback();
        t_reset();
        t_crc();
        close_out();
    end
    initial begin
        #2000000 num_errors++;
        close_out();
    end
endmodule : serial_frame_and_load_control_test
